// [rtl/aopc_regs.v]
/*
  offset, line-pll and clamp register bank of a triple-channel digitiser,
  with coast and clamp timing. assumes a same-clock register master and
  sync pins from outside the clock domain; pixelTick is a clk_sys enable.
*/
// Overview of operation
// [R01] offset low registers hold two LSBs in 7:6
// [R02] loop off drives DAC, on adds digital offset
// [R03] line total is fourteen bits, high:low
// [R04] new line total taken on low write
// [R05] six-bit phase, 64 steps of 5.625 degrees
// [R06] internal coast starts lines before vsync
// [R07] internal coast lasts lines after vsync
// [R08] option bit 0 picks pll lock edge
// [R09] option bit 1 gates clock invert pin
// [R10] option bit 2 picks external coast source
// [R11] option bit 3 sets external coast polarity
// [R12] option bit 4 picks external pixel clock
// [R13] restore start counts pixels from hsync trailing
// [R14] clamp width governs DC restore clamp only
// [R15] zero width never connects the clamp
// [R16] digital offset word is offset binary
// [R17] oversampling multiplies totals, start and widths
// [R18] clamp each line from start for width
`timescale 1ns/10ps
`include "aopc_consts.vh"
module aopc_regs #(
  parameter LINE_W = 12
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [7:0] regRdData,
  input wire blackLevelLoopOn,
  input wire [1:0] oversampleSel,
  input wire pixelTick,
  input wire hsyncPin,
  input wire vsyncPin,
  input wire coastPin,
  input wire clockInvertInput,
  output reg [1:0] redOffsetLow,
  output reg [7:0] greenOffsetDac,
  output reg [7:0] blueOffsetDac,
  output reg [9:0] greenDigitalOffset,
  output reg [9:0] blueDigitalOffset,
  output reg [16:0] lineTotal,
  output reg lineTotalLoad,
  output reg [5:0] samplingPhase,
  output reg pllRefEdge,
  output reg clockInvertActive,
  output reg externalPixelClock,
  output wire pllCoast,
  output reg [16:0] restoreStart,
  output reg [10:0] clampWidthScaled,
  output wire clampPulse,
  output wire blackLevelStart
);
  // register storage
  reg [1:0] redOffLo_reg;
  reg [7:0] grnOffHi_reg;
  reg [1:0] grnOffLo_reg;
  reg [7:0] bluOffHi_reg;
  reg [1:0] bluOffLo_reg;
  reg [5:0] totalHi_reg;
  reg [7:0] totalLo_reg;
  reg [13:0] totalLive_reg;
  reg [5:0] phase_reg;
  reg [7:0] coastPre_reg;
  reg [7:0] coastPost_reg;
  reg [4:0] pllOpt_reg;
  reg [5:0] startHi_reg;
  reg [7:0] startLo_reg;
  reg [7:0] clampW_reg;
  reg [7:0] rdData_next;
  reg [16:0] totalScaled_next;
  reg [16:0] startScaled_next;
  reg [10:0] widthScaled_next;

  // synchronisers: hsync, vsync, coast, clock invert
  reg [3:0] pinMeta_reg;
  reg [3:0] pinSync_reg;
  reg [1:0] syncDly_reg;
  wire hsyncS;
  wire vsyncS;
  wire hsyncLead;
  wire hsyncTrail;
  wire vsyncStart;
  wire vsyncEnd;

  wire [9:0] grnWord;
  wire [9:0] bluWord;
  wire [13:0] startWord;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_reg <= 4'h0;
      pinSync_reg <= 4'h0;
      syncDly_reg <= 2'h0;
    end else begin
      pinMeta_reg <= {clockInvertInput, coastPin, vsyncPin, hsyncPin};
      pinSync_reg <= pinMeta_reg;
      syncDly_reg <= pinSync_reg[1:0];
    end
  end

  assign hsyncS = pinSync_reg[0];
  assign vsyncS = pinSync_reg[1];
  // sync is taken as active high: leading edge rises, trailing edge falls
  assign hsyncLead = hsyncS & ~syncDly_reg[0];
  assign hsyncTrail = ~hsyncS & syncDly_reg[0];
  assign vsyncStart = vsyncS & ~syncDly_reg[1];
  assign vsyncEnd = ~vsyncS & syncDly_reg[1];

  // register writes
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      redOffLo_reg <= `AOPC_RST_OFF_LO;
      grnOffHi_reg <= `AOPC_RST_OFF_HI;
      grnOffLo_reg <= `AOPC_RST_OFF_LO;
      bluOffHi_reg <= `AOPC_RST_OFF_HI;
      bluOffLo_reg <= `AOPC_RST_OFF_LO;
      totalHi_reg <= `AOPC_RST_TOTAL_HI;
      totalLo_reg <= `AOPC_RST_TOTAL_LO;
      totalLive_reg <= {`AOPC_RST_TOTAL_HI, `AOPC_RST_TOTAL_LO};
      phase_reg <= `AOPC_RST_PHASE;
      coastPre_reg <= `AOPC_RST_COAST_PRE;
      coastPost_reg <= `AOPC_RST_COAST_POST;
      pllOpt_reg <= `AOPC_RST_PLL_OPT;
      startHi_reg <= `AOPC_RST_START_HI;
      startLo_reg <= `AOPC_RST_START_LO;
      clampW_reg <= `AOPC_RST_CLAMP_W;
      lineTotalLoad <= 1'b0;
    end else begin
      lineTotalLoad <= 1'b0;
      if (regWrEn) begin
        if (regAddr == `AOPC_ADDR_RED_OFF_LO) begin
          redOffLo_reg <= regWrData[`AOPC_OFF_LO_MSB:`AOPC_OFF_LO_LSB]; // R01
        end else if (regAddr == `AOPC_ADDR_GRN_OFF_HI) begin
          grnOffHi_reg <= regWrData;
        end else if (regAddr == `AOPC_ADDR_GRN_OFF_LO) begin
          grnOffLo_reg <= regWrData[`AOPC_OFF_LO_MSB:`AOPC_OFF_LO_LSB]; // R01
        end else if (regAddr == `AOPC_ADDR_BLU_OFF_HI) begin
          bluOffHi_reg <= regWrData;
        end else if (regAddr == `AOPC_ADDR_BLU_OFF_LO) begin
          bluOffLo_reg <= regWrData[`AOPC_OFF_LO_MSB:`AOPC_OFF_LO_LSB]; // R01
        end else if (regAddr == `AOPC_ADDR_TOTAL_HI) begin
          // staged only: the pll keeps its old total until the low byte
          totalHi_reg <= regWrData[5:0]; // R03
        end else if (regAddr == `AOPC_ADDR_TOTAL_LO) begin
          totalLo_reg <= regWrData;
          totalLive_reg <= {totalHi_reg, regWrData}; // R04
          lineTotalLoad <= 1'b1; // R04
        end else if (regAddr == `AOPC_ADDR_PHASE) begin
          phase_reg <= regWrData[5:0]; // R05
        end else if (regAddr == `AOPC_ADDR_COAST_PRE) begin
          coastPre_reg <= regWrData;
        end else if (regAddr == `AOPC_ADDR_COAST_POST) begin
          coastPost_reg <= regWrData;
        end else if (regAddr == `AOPC_ADDR_PLL_OPT) begin
          // only five option bits exist; the rest read back zero
          pllOpt_reg <= regWrData[4:0];
        end else if (regAddr == `AOPC_ADDR_START_HI) begin
          startHi_reg <= regWrData[5:0]; // R13
        end else if (regAddr == `AOPC_ADDR_START_LO) begin
          startLo_reg <= regWrData;
        end else if (regAddr == `AOPC_ADDR_CLAMP_W) begin
          clampW_reg <= regWrData;
        end
      end
    end
  end

  // read decode; unused bits and unmapped addresses read zero
  always @* begin
    rdData_next = `AOPC_UNMAPPED_READ;
    if (regAddr == `AOPC_ADDR_RED_OFF_LO) begin
      rdData_next = {redOffLo_reg, 6'h00};
    end else if (regAddr == `AOPC_ADDR_GRN_OFF_HI) begin
      rdData_next = grnOffHi_reg;
    end else if (regAddr == `AOPC_ADDR_GRN_OFF_LO) begin
      rdData_next = {grnOffLo_reg, 6'h00};
    end else if (regAddr == `AOPC_ADDR_BLU_OFF_HI) begin
      rdData_next = bluOffHi_reg;
    end else if (regAddr == `AOPC_ADDR_BLU_OFF_LO) begin
      rdData_next = {bluOffLo_reg, 6'h00};
    end else if (regAddr == `AOPC_ADDR_TOTAL_HI) begin
      rdData_next = {2'h0, totalHi_reg};
    end else if (regAddr == `AOPC_ADDR_TOTAL_LO) begin
      rdData_next = totalLo_reg;
    end else if (regAddr == `AOPC_ADDR_PHASE) begin
      rdData_next = {2'h0, phase_reg};
    end else if (regAddr == `AOPC_ADDR_COAST_PRE) begin
      rdData_next = coastPre_reg;
    end else if (regAddr == `AOPC_ADDR_COAST_POST) begin
      rdData_next = coastPost_reg;
    end else if (regAddr == `AOPC_ADDR_PLL_OPT) begin
      rdData_next = {3'h0, pllOpt_reg};
    end else if (regAddr == `AOPC_ADDR_START_HI) begin
      rdData_next = {2'h0, startHi_reg};
    end else if (regAddr == `AOPC_ADDR_START_LO) begin
      rdData_next = startLo_reg;
    end else if (regAddr == `AOPC_ADDR_CLAMP_W) begin
      rdData_next = clampW_reg;
    end
  end

  // data stands only in the cycle after the strobe, so stale reads show zero
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      regRdData <= rdData_next;
    end else begin
      regRdData <= 8'h00;
    end
  end

  // ten-bit offset words: high byte above the two low bits
  assign grnWord = {grnOffHi_reg, grnOffLo_reg};
  assign bluWord = {bluOffHi_reg, bluOffLo_reg};
  assign startWord = {startHi_reg, startLo_reg};

  // oversampling scale: the ratio is a power of two, so the product is a
  // plain shift into the wider output word
  always @* begin
    totalScaled_next = {3'h0, totalLive_reg};
    startScaled_next = {3'h0, startWord};
    widthScaled_next = {3'h0, clampW_reg};
    case (oversampleSel)
      2'h1: begin
        totalScaled_next = {2'h0, totalLive_reg, 1'b0}; // R17
        startScaled_next = {2'h0, startWord, 1'b0}; // R17
        widthScaled_next = {2'h0, clampW_reg, 1'b0}; // R17
      end
      2'h2: begin
        totalScaled_next = {1'b0, totalLive_reg, 2'h0}; // R17
        startScaled_next = {1'b0, startWord, 2'h0}; // R17
        widthScaled_next = {1'b0, clampW_reg, 2'h0}; // R17
      end
      2'h3: begin
        totalScaled_next = {totalLive_reg, 3'h0}; // R17
        startScaled_next = {startWord, 3'h0}; // R17
        widthScaled_next = {clampW_reg, 3'h0}; // R17
      end
      default: begin
        totalScaled_next = {3'h0, totalLive_reg};
        startScaled_next = {3'h0, startWord};
        widthScaled_next = {3'h0, clampW_reg};
      end
    endcase
  end

  // offset steering
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      redOffsetLow <= 2'h0;
      greenOffsetDac <= `AOPC_DAC_MID;
      blueOffsetDac <= `AOPC_DAC_MID;
      greenDigitalOffset <= 10'h000;
      blueDigitalOffset <= 10'h000;
    end else begin
      redOffsetLow <= redOffLo_reg;
      if (blackLevelLoopOn) begin
        // dac parked at mid scale, word becomes a signed adder value
        greenOffsetDac <= `AOPC_DAC_MID; // R02
        blueOffsetDac <= `AOPC_DAC_MID; // R02
        greenDigitalOffset <= grnWord - `AOPC_DIG_ZERO; // R16
        blueDigitalOffset <= bluWord - `AOPC_DIG_ZERO; // R16
      end else begin
        greenOffsetDac <= grnOffHi_reg; // R02
        blueOffsetDac <= bluOffHi_reg; // R02
        greenDigitalOffset <= 10'h000;
        blueDigitalOffset <= 10'h000;
      end
    end
  end

  // scaled timing words follow the oversampling select one clock later
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lineTotal <= 17'h00000;
      restoreStart <= 17'h00000;
      clampWidthScaled <= 11'h000;
    end else begin
      lineTotal <= totalScaled_next; // R17
      restoreStart <= startScaled_next; // R13
      clampWidthScaled <= widthScaled_next; // R14
    end
  end

  // option decode; the lock edge pulse trails the pin by three clocks
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      samplingPhase <= 6'h00;
      pllRefEdge <= 1'b0;
      clockInvertActive <= 1'b0;
      externalPixelClock <= 1'b0;
    end else begin
      samplingPhase <= phase_reg; // R05
      if (pllOpt_reg[`AOPC_OPT_LEAD_EDGE]) begin
        pllRefEdge <= hsyncLead; // R08
      end else begin
        pllRefEdge <= hsyncTrail; // R08
      end
      clockInvertActive <= pllOpt_reg[`AOPC_OPT_CLOCK_INVERT_INPUT_EN] & pinSync_reg[3]; // R09
      externalPixelClock <= pllOpt_reg[`AOPC_OPT_EXT_CLOCK]; // R12
    end
  end

  // coast runs on the synchronised levels, so it trails the pins
  aopc_coast_gen #(
    .LINE_W(LINE_W)
  ) uCoast (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .linePulse(hsyncLead),
    .vsyncLevel(vsyncS),
    .vsyncStart(vsyncStart),
    .vsyncEnd(vsyncEnd),
    .coastExtLevel(pinSync_reg[2]),
    .coastActiveLow(pllOpt_reg[`AOPC_OPT_COAST_POL]),
    .coastExternal(pllOpt_reg[`AOPC_OPT_EXT_COAST]),
    .linesBefore(coastPre_reg),
    .linesAfter(coastPost_reg),
    .coast(pllCoast)
  );

  // clamp timing uses the scaled start and width, counted in pixel ticks
  aopc_clamp_gen #(
    .PIX_W(17),
    .CW_W(11)
  ) uClamp (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pixelTick(pixelTick),
    .hsyncTrail(hsyncTrail),
    .startPixel(restoreStart),
    .clampWidth(clampWidthScaled),
    .clampPulse(clampPulse),
    .blackStart(blackLevelStart)
  );
endmodule

// [rtl/aopc_consts.vh]
/*
  register offsets, reset values, field positions and fixed codes of the
  offset, line-pll and clamp register bank. assumes an 8-bit register port.
*/
`ifndef AOPC_CONSTS_VH
`define AOPC_CONSTS_VH

`define AOPC_ADDR_RED_OFF_LO 8'h19
`define AOPC_ADDR_GRN_OFF_HI 8'h1a
`define AOPC_ADDR_GRN_OFF_LO 8'h1b
`define AOPC_ADDR_BLU_OFF_HI 8'h1c
`define AOPC_ADDR_BLU_OFF_LO 8'h1d
`define AOPC_ADDR_TOTAL_HI 8'h1e
`define AOPC_ADDR_TOTAL_LO 8'h1f
`define AOPC_ADDR_PHASE 8'h20
`define AOPC_ADDR_COAST_PRE 8'h21
`define AOPC_ADDR_COAST_POST 8'h22
`define AOPC_ADDR_PLL_OPT 8'h23
`define AOPC_ADDR_START_HI 8'h24
`define AOPC_ADDR_START_LO 8'h25
`define AOPC_ADDR_CLAMP_W 8'h26

`define AOPC_RST_OFF_LO 2'h0
`define AOPC_RST_OFF_HI 8'h80
`define AOPC_RST_TOTAL_HI 6'h06
`define AOPC_RST_TOTAL_LO 8'h98
`define AOPC_RST_PHASE 6'h00
`define AOPC_RST_COAST_PRE 8'h04
`define AOPC_RST_COAST_POST 8'h04
`define AOPC_RST_PLL_OPT 5'h00
`define AOPC_RST_START_HI 6'h00
`define AOPC_RST_START_LO 8'h02
`define AOPC_RST_CLAMP_W 8'h10

`define AOPC_OFF_LO_MSB 7
`define AOPC_OFF_LO_LSB 6
`define AOPC_OPT_LEAD_EDGE 0
`define AOPC_OPT_CLOCK_INVERT_INPUT_EN 1
`define AOPC_OPT_EXT_COAST 2
`define AOPC_OPT_COAST_POL 3
`define AOPC_OPT_EXT_CLOCK 4

`define AOPC_DAC_MID 8'h80
`define AOPC_DIG_ZERO 10'h200
`define AOPC_UNMAPPED_READ 8'h00

`endif

// [rtl/aopc_coast_gen.v]
/*
  coast generator: holds the line pll off sync around vertical sync.
  assumes synchronised, same-clock sync levels and one-cycle line pulses.
*/
`timescale 1ns/10ps
module aopc_coast_gen #(
  parameter LINE_W = 12
) (
  input wire clk_sys,
  input wire rst_b,
  input wire linePulse,
  input wire vsyncLevel,
  input wire vsyncStart,
  input wire vsyncEnd,
  input wire coastExtLevel,
  input wire coastActiveLow,
  input wire coastExternal,
  input wire [7:0] linesBefore,
  input wire [7:0] linesAfter,
  output reg coast
);
  reg [LINE_W-1:0] lineCount_reg;
  reg [LINE_W-1:0] frameLines_reg;
  reg [7:0] postLeft_reg;
  wire [LINE_W-1:0] linesToVsync;
  wire preActive;
  wire extActive;

  // the vsync start is predicted from the previous frame's length
  assign linesToVsync = frameLines_reg - lineCount_reg;
  assign preActive = (frameLines_reg != {LINE_W{1'b0}}) &&
                     (linesToVsync <= {{(LINE_W-8){1'b0}}, linesBefore}); // R06
  assign extActive = coastActiveLow ? ~coastExtLevel : coastExtLevel; // R11

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lineCount_reg <= {LINE_W{1'b0}};
      frameLines_reg <= {LINE_W{1'b0}};
      postLeft_reg <= 8'h00;
      coast <= 1'b0;
    end else begin
      if (vsyncStart) begin
        frameLines_reg <= lineCount_reg;
        lineCount_reg <= {LINE_W{1'b0}};
      end else if (linePulse && lineCount_reg != {LINE_W{1'b1}}) begin
        lineCount_reg <= lineCount_reg + 1'b1;
      end
      if (vsyncEnd) begin
        postLeft_reg <= linesAfter; // R07
      end else if (linePulse && postLeft_reg != 8'h00) begin
        postLeft_reg <= postLeft_reg - 1'b1;
      end
      if (coastExternal) begin
        coast <= extActive; // R10
      end else begin
        coast <= preActive | vsyncLevel | (postLeft_reg != 8'h00) | vsyncEnd; // R10
      end
    end
  end
endmodule

// [rtl/aopc_clamp_gen.v]
/*
  clamp pulse generator: counts pixel clocks from the synchronised hsync trailing
  edge. assumes pixelTick is a one-cycle enable at the pixel rate.
*/
`timescale 1ns/10ps
module aopc_clamp_gen #(
  parameter PIX_W = 17,
  parameter CW_W = 11
) (
  input wire clk_sys,
  input wire rst_b,
  input wire pixelTick,
  input wire hsyncTrail,
  input wire [PIX_W-1:0] startPixel,
  input wire [CW_W-1:0] clampWidth,
  output reg clampPulse,
  output reg blackStart
);
  reg [PIX_W-1:0] pixCount_reg;
  reg counting_reg;
  reg [CW_W-1:0] widthLeft_reg;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pixCount_reg <= {PIX_W{1'b0}};
      counting_reg <= 1'b0;
      widthLeft_reg <= {CW_W{1'b0}};
      clampPulse <= 1'b0;
      blackStart <= 1'b0;
    end else begin
      blackStart <= 1'b0;
      if (hsyncTrail) begin
        pixCount_reg <= {PIX_W{1'b0}}; // R13
        counting_reg <= 1'b1;
        widthLeft_reg <= {CW_W{1'b0}};
        clampPulse <= 1'b0;
      end else if (pixelTick) begin
        if (counting_reg && pixCount_reg == startPixel) begin
          counting_reg <= 1'b0;
          blackStart <= 1'b1; // R13
          // a zero width never connects the clamp
          if (clampWidth != {CW_W{1'b0}}) begin
            clampPulse <= 1'b1; // R15
            widthLeft_reg <= clampWidth - 1'b1; // R18
          end
        end else if (widthLeft_reg != {CW_W{1'b0}}) begin
          widthLeft_reg <= widthLeft_reg - 1'b1;
        end else begin
          clampPulse <= 1'b0; // R14
        end
        if (counting_reg) begin
          pixCount_reg <= pixCount_reg + 1'b1;
        end
      end
    end
  end
endmodule

// [bench/aopc_assertions.sv]
/*
  checker for the register bank: bus timing, offset, line total and clamp
  relations. assumes one clock domain and a bind from the bench top.
*/
`timescale 1ns/10ps
module aopc_assertions (
  input wire clk_sys,
  input wire rst_b,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regRdData,
  input wire blackLevelLoopOn,
  input wire [1:0] redOffsetLow,
  input wire [7:0] greenOffsetDac,
  input wire [9:0] greenDigitalOffset,
  input wire lineTotalLoad,
  input wire [5:0] samplingPhase,
  input wire [10:0] clampWidthScaled,
  input wire clampPulse,
  input wire blackLevelStart
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  chk_load_pulse: assert property (regWrEn && regAddr == 8'h1f |=> lineTotalLoad)
    else $error("no load after low byte write");
  chk_load_only: assert property (!(regWrEn && regAddr == 8'h1f) |=> !lineTotalLoad)
    else $error("load without low byte write");
  chk_read_idle: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
    else $error("read data outside read cycle");
  chk_dac_park: assert property (blackLevelLoopOn [*2] |=> greenOffsetDac == 8'h80)
    else $error("dac not parked with loop on");
  chk_dig_off: assert property (!blackLevelLoopOn [*2] |=> greenDigitalOffset == 10'h000)
    else $error("digital offset with loop off");
  chk_clamp_zero: assert property ($rose(clampPulse) |-> $past(clampWidthScaled) != 11'h0)
    else $error("clamp with zero width");
  chk_clamp_start: assert property ($rose(clampPulse) |-> blackLevelStart)
    else $error("clamp rose without start");
  chk_phase_wr: assert property (regWrEn && regAddr == 8'h20 |->
    ##2 samplingPhase == $past(regWrData[5:0], 2))
    else $error("phase not taken");
  chk_red_low: assert property (regWrEn && regAddr == 8'h19 |->
    ##2 redOffsetLow == $past(regWrData[7:6], 2))
    else $error("red low bits not taken");
endmodule

// [bench/aopc_host_model.sv]
/*
  host side of the register port: one-cycle strobes, read data taken in
  the cycle after the read strobe. assumes the bank never stalls.
*/
`timescale 1ns/10ps
module aopc_host_model (
  input wire clk_sys,
  output reg [7:0] regAddr,
  output reg [7:0] regWrData,
  output reg regWrEn,
  output reg regRdEn,
  input wire [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  // callers send the line total high byte before the low byte
  task wr(input [7:0] a, input [7:0] v);
    begin
      regAddr <= a;
      regWrData <= v;
      regWrEn <= 1'b1;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
      // released lines flip so stale values cannot pass
      regWrData <= ~v;
      regAddr <= ~a;
      @(posedge clk_sys);
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk_sys);
      regRdEn <= 1'b0;
      regAddr <= ~a;
      @(posedge clk_sys);
      v = regRdData;
    end
  endtask
endmodule

// [bench/aopc_regs_tb.sv]
/*
  bench top: random and corner traffic through the host model, expected
  values from the register table. assumes the bank at 125 MHz.
*/
`timescale 1ns/10ps
module aopc_regs_tb;
  localparam [111:0] RSTV = 112'h00_80_00_80_00_06_98_00_04_04_00_00_02_10;
  localparam [111:0] MASK = 112'hc0_ff_c0_ff_c0_3f_ff_3f_ff_ff_1f_3f_ff_ff;
  reg clk_sys;
  reg rst_b;
  reg blackLevelLoopOn;
  reg [1:0] oversampleSel;
  reg pixelTick;
  reg hsyncPin;
  reg vsyncPin;
  reg coastPin;
  reg clockInvertInput;
  reg tickAll;
  wire [7:0] regAddr, regWrData, regRdData, greenOffsetDac, blueOffsetDac;
  wire regWrEn, regRdEn, lineTotalLoad, pllRefEdge, clockInvertActive;
  wire externalPixelClock, pllCoast, clampPulse, blackLevelStart;
  wire [1:0] redOffsetLow;
  wire [9:0] greenDigitalOffset, blueDigitalOffset;
  wire [16:0] lineTotal, restoreStart;
  wire [5:0] samplingPhase;
  wire [10:0] clampWidthScaled;
  integer seed, num_errors, samples_checked, i, n, m, e, p, j;
  reg [31:0] r;
  reg [31:0] r2;
  reg [7:0] d;
  reg [7:0] wv [0:13];
  reg [13:0] tot;

  aopc_host_model i_host (.clk_sys, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData);
  aopc_regs i_dut (.clk_sys, .rst_b, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .blackLevelLoopOn, .oversampleSel, .pixelTick, .hsyncPin, .vsyncPin,
    .coastPin, .clockInvertInput, .redOffsetLow, .greenOffsetDac, .blueOffsetDac,
    .greenDigitalOffset, .blueDigitalOffset, .lineTotal, .lineTotalLoad, .samplingPhase,
    .pllRefEdge, .clockInvertActive, .externalPixelClock, .pllCoast, .restoreStart,
    .clampWidthScaled, .clampPulse, .blackLevelStart);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    r2 = $random(seed);
    pixelTick <= tickAll | r2[0];
  end
  function [9:0] digOff(input [7:0] hi, input [7:0] lo);
    digOff = {hi, lo[7:6]} - 10'h200;
  endfunction
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task stop_test;
    begin
      if (num_errors == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge clk_sys);
  endtask
  // counts clamp cycles, start pulses and pll edge pulses over k cycles
  task cnt(input integer k);
    begin
      n = 0;
      m = 0;
      e = 0;
      p = 0;
      for (j = 1; j <= k; j = j + 1) begin
        @(posedge clk_sys);
        n = n + clampPulse;
        m = m + blackLevelStart;
        e = e + pllRefEdge;
        if (blackLevelStart === 1'b1) p = j;
      end
    end
  endtask
  task hline;
    begin
      hsyncPin <= 1'b1;
      tick(2);
      hsyncPin <= 1'b0;
      tick(8);
    end
  endtask

  initial begin
    seed = 32'h2190;
    num_errors = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    {blackLevelLoopOn, oversampleSel, hsyncPin, vsyncPin, coastPin} = 6'h0;
    {clockInvertInput, tickAll} = 2'h0;
    tick(4);
    rst_b <= 1'b1;
    tick(2);
    chk("total", lineTotal, 17'h698);
    chk("start", restoreStart, 17'h2);
    chk("width", clampWidthScaled, 11'h10);
    for (i = 0; i < 14; i = i + 1) begin
      i_host.rd(8'h19 + i[7:0], d);
      chk("reset", d, RSTV[111 - 8 * i -: 8]);
    end
    i_host.rd(8'h27, d);
    chk("unmapped", d, 8'h00);
    for (i = 0; i < 14; i = i + 1) begin
      r = $random(seed);
      wv[i] = r[7:0] & MASK[111 - 8 * i -: 8];
      i_host.wr(8'h19 + i[7:0], r[7:0]);
      i_host.rd(8'h19 + i[7:0], d);
      chk("readback", d, wv[i]);
    end
    tot = {wv[5][5:0], wv[6]};
    wv[5] = ~wv[5] & 8'h3f;
    i_host.wr(8'h1e, wv[5]);
    tick(3);
    chk("staged", lineTotal, tot);
    i_host.wr(8'h1f, wv[6]);
    tot = {wv[5][5:0], wv[6]};
    for (i = 0; i < 4; i = i + 1) begin
      oversampleSel <= i[1:0];
      tick(3);
      chk("total", lineTotal, {3'h0, tot} << i);
      chk("start", restoreStart, {3'h0, wv[11][5:0], wv[12]} << i);
      chk("width", clampWidthScaled, {3'h0, wv[13]} << i);
    end
    chk("red", redOffsetLow, wv[0][7:6]);
    chk("gdac", greenOffsetDac, wv[1]);
    chk("bdac", blueOffsetDac, wv[3]);
    chk("phase", samplingPhase, wv[7]);
    i_host.wr(8'h1a, 8'h00);
    i_host.wr(8'h1b, 8'hff);
    i_host.wr(8'h1c, 8'hff);
    i_host.wr(8'h1d, 8'hc0);
    blackLevelLoopOn <= 1'b1;
    tick(3);
    chk("gdig", greenDigitalOffset, digOff(8'h00, 8'hff));
    chk("bdig", blueDigitalOffset, digOff(8'hff, 8'hc0));
    chk("bdac", blueOffsetDac, 8'h80);
    blackLevelLoopOn <= 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
      r = $random(seed);
      coastPin <= r[1];
      clockInvertInput <= r[2];
      i_host.wr(8'h23, {3'h0, i[3:0], r[0]});
      tick(5);
      chk("extclk", externalPixelClock, i[3]);
      chk("clock_invert_input", clockInvertActive, i[0] & r[2]);
      if (i[1]) chk("coast", pllCoast, r[1] ^ i[2]);
    end
    oversampleSel <= 2'h0;
    i_host.wr(8'h24, 8'h00);
    i_host.wr(8'h25, 8'h03);
    i_host.wr(8'h26, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      i_host.wr(8'h23, {7'h0, i[0]});
      hsyncPin <= 1'b1;
      cnt(6);
      chk("lead", e, i);
      hsyncPin <= 1'b0;
      cnt(6);
      chk("trail", e, 1 - i);
    end
    tickAll <= 1'b1;
    for (i = 0; i < 3; i = i + 1) begin
      i_host.wr(8'h26, i[7:0] * 8'h05);
      hsyncPin <= 1'b1;
      tick(4);
      hsyncPin <= 1'b0;
      cnt(40);
      chk("clamp", n, i * 5);
      chk("black", m, 1);
      chk("startpix", p, 8);
    end
    i_host.wr(8'h23, 8'h00);
    i_host.wr(8'h22, 8'h03);
    vsyncPin <= 1'b1;
    hline;
    hline;
    chk("coast", pllCoast, 1'b1);
    vsyncPin <= 1'b0;
    hline;
    chk("coast", pllCoast, 1'b1);
    repeat (5) hline;
    chk("coast", pllCoast, 1'b0);
    i_host.wr(8'h22, 8'h00);
    i_host.wr(8'h21, 8'h02);
    // frames of eight lines: coast three lines out is off, one line out is on
    for (i = 0; i < 2; i = i + 1) begin
      vsyncPin <= 1'b1;
      hline;
      vsyncPin <= 1'b0;
      repeat (4) hline;
      chk("precoast", pllCoast, 1'b0);
      repeat (2) hline;
      chk("precoast", pllCoast, 1'b1);
      hline;
    end
    stop_test;
  end
  initial begin
    #400000;
    num_errors = num_errors + 1;
    stop_test;
  end
endmodule

bind aopc_regs aopc_assertions i_chk (.clk_sys, .rst_b, .regAddr, .regWrData, .regWrEn,
  .regRdEn, .regRdData, .blackLevelLoopOn, .redOffsetLow, .greenOffsetDac,
  .greenDigitalOffset, .lineTotalLoad, .samplingPhase, .clampWidthScaled, .clampPulse,
  .blackLevelStart);
